// *** pkg/pms_consts.vh ***
`ifndef PMS_CONSTS_VH
`define PMS_CONSTS_VH

// Mode encoding
`define PMS_MODE_SLEEP 2'h0
`define PMS_MODE_ON 2'h1
`define PMS_MODE_LIMP 2'h2

// Reset values
`define PMS_CTRL_RST 8'h00
`define PMS_OUT_RST 8'h00

// Two-flop synchroniser depth
`define PMS_SYNC_STAGES 2

`endif

// *** hw/pms_sync.v ***
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for asynchronous level inputs
module pms_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // Data
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // pms_sync
`default_nettype wire

// *** hw/pms_power_mode_sequencer.v ***
`timescale 1ns/1ps
`default_nettype none
`include "pms_consts.vh"
module pms_power_mode_sequencer #(
  parameter CH = 8
) (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // Supply monitors (asynchronous levels)
  input wire vbb_ok,
  input wire vdd_ok,
  // Limp home pin (asynchronous level)
  input wire limp_home_input,
  // Decoded serial command, one-cycle strobe in ref_clk domain
  input wire cmd_valid,
  input wire wake_command_bit,
  input wire standby_command_bit,
  input wire [CH-1:0] cmd_ctrl,
  // Limp home output pattern
  input wire [CH-1:0] limp_pattern,
  // Serial shift path
  input wire spi_sclk_rise,
  input wire spi_si,
  output reg spi_so,
  // Status and outputs
  output reg [1:0] mode,
  output reg [CH-1:0] ctrl_bank,
  output reg [CH-1:0] chan_out,
  output wire shift_active
);
  ////////////////////////////////////////////////////////////////////////////
  wire vbb_s;
  wire vdd_s;
  wire limp_s;

  pms_sync #(.WIDTH(3)) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in({vbb_ok, vdd_ok, limp_home_input}),
    .sync_out({vbb_s, vdd_s, limp_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  reg [1:0] mode_q;
  reg [1:0] mode_d;
  reg [CH-1:0] ctrl_q;
  reg [CH-1:0] ctrl_d;
  reg [CH-1:0] shift_q;
  reg [CH-1:0] shift_d;
  // Commands only act while the logic supply lets the serial port work
  wire cmd_ok = cmd_valid & vdd_s;

  always @* begin
    mode_d = mode_q;
    ctrl_d = ctrl_q;
    if (!vbb_s) begin
      // Battery undervoltage: mode and configuration back to defaults
      mode_d = `PMS_MODE_SLEEP;
      ctrl_d = `PMS_CTRL_RST;
    end else begin
      case (mode_q)
        `PMS_MODE_SLEEP: begin
          if (limp_s) begin
            mode_d = `PMS_MODE_LIMP;
          end else if (cmd_ok && wake_command_bit && !standby_command_bit) begin
            mode_d = `PMS_MODE_ON;
          end
        end
        `PMS_MODE_ON: begin
          if (limp_s) begin
            mode_d = `PMS_MODE_LIMP;
          end else if (cmd_ok && standby_command_bit) begin
            // Standby wins over wake if both set
            mode_d = `PMS_MODE_SLEEP;
            ctrl_d = `PMS_CTRL_RST;
          end else if (cmd_ok) begin
            ctrl_d = cmd_ctrl;
          end
          // No command: configuration simply held, also during cranking
        end
        `PMS_MODE_LIMP: begin
          if (!limp_s) begin
            mode_d = `PMS_MODE_SLEEP;
            ctrl_d = `PMS_CTRL_RST;
          end
        end
        default: begin
          mode_d = `PMS_MODE_SLEEP;
          ctrl_d = `PMS_CTRL_RST;
        end
      endcase
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= `PMS_MODE_SLEEP;
      ctrl_q <= `PMS_CTRL_RST;
    end else begin
      mode_q <= mode_d;
      ctrl_q <= ctrl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift path depends on the logic supply only
  assign shift_active = vdd_s;

  always @* begin
    shift_d = shift_q;
    if (vdd_s && spi_sclk_rise) begin
      shift_d = {shift_q[CH-2:0], spi_si};
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shift_q <= {CH{1'b0}};
      spi_so <= 1'b0;
      mode <= `PMS_MODE_SLEEP;
      ctrl_bank <= `PMS_CTRL_RST;
      chan_out <= `PMS_OUT_RST;
    end else begin
      shift_q <= shift_d;
      // Daisy chain out: MSB leaves first
      spi_so <= vdd_s ? shift_q[CH-1] : 1'b0;
      mode <= mode_q;
      ctrl_bank <= ctrl_q;
      // Outputs follow stored configuration (limp_pattern in limp home mode), not the logic supply
      case (mode_q)
        `PMS_MODE_ON: chan_out <= ctrl_q;
        `PMS_MODE_LIMP: chan_out <= limp_pattern;
        default: chan_out <= `PMS_OUT_RST;
      endcase
    end
  end
endmodule // pms_power_mode_sequencer
`default_nettype wire

// *** test/pms_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module pms_host(input wire ref_clk, output var logic cv = 0, wk = 0, sb = 0,
  output var logic [7:0] cc = 8'h00);
  task send(input logic w, s, input logic [7:0] c);
    @(posedge ref_clk) #2 {cv, wk, sb, cc} = {1'b1, w, s, c};
    // Stale data would hide a missed qualifier
    @(posedge ref_clk) #2 {cv, cc} = {1'b0, ~c};
  endtask
endmodule // pms_host
`default_nettype wire

// *** test/pms_power_mode_sequencer_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module pms_monitor(input wire ref_clk, resetn, vbb_ok, vdd_ok, limp_home_input, spi_so,
  input wire [1:0] mode, input wire [7:0] ctrl_bank, chan_out);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  uv_reset_a: assert property (!vbb_ok [*3] |-> ##[0:2] !ctrl_bank) else $error("uv");
  sleep_bank_a: assert property (!mode |-> !ctrl_bank) else $error("bank");
  limp_on_a: assert property (
    (limp_home_input && vbb_ok) [*5] |-> mode == 2'h2) else $error("limp");
  limp_end_a: assert property ($fell(limp_home_input) |-> ##[1:5] !mode) else $error("exit");
  so_idle_a: assert property (!vdd_ok [*4] |-> !spi_so) else $error("so");
  out_hold_a: assert property (
    (!vdd_ok && vbb_ok && !limp_home_input) [*3] |=> $stable(chan_out)) else $error("hold");
  cover property (mode == 2'h1);
  cover property (mode == 2'h2);
  cover property (!vdd_ok [*3]);
endmodule // pms_monitor
bind pms_power_mode_sequencer pms_monitor u_mon(.ref_clk, .resetn, .vbb_ok, .vdd_ok,
  .limp_home_input, .spi_so, .mode, .ctrl_bank, .chan_out);
`default_nettype wire

// *** test/pms_power_mode_sequencer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module pms_power_mode_sequencer_tb;
  logic ref_clk = 0, resetn = 0, vbb = 1, vdd = 1, lh = 0, sr = 0, cv, wk, sb, so;
  logic [7:0] cc, cb, co;
  logic [1:0] md;
  logic sa;
  // Rows: wake, standby, ctrl, mode, chan_out
  logic [19:0] t[5] = '{20'h80100, 20'h0F13C, 20'hFFC00, 20'h96900, 20'h0F13C};
  int failures = 0, num_checks = 0, cyc = 0;
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cyc > 3000) begin failures++; results; end
  pms_host u_pms_host(.ref_clk, .cv, .wk, .sb, .cc);
  pms_power_mode_sequencer u_pms_power_mode_sequencer(.ref_clk, .resetn, .vbb_ok(vbb),
    .vdd_ok(vdd), .limp_home_input(lh), .cmd_valid(cv), .wake_command_bit(wk),
    .standby_command_bit(sb), .cmd_ctrl(cc), .limp_pattern(8'hA5), .spi_sclk_rise(sr),
    .spi_si(1'b1), .spi_so(so), .mode(md), .ctrl_bank(cb), .chan_out(co), .shift_active(sa));
  task chk(input logic [7:0] g, e);
    num_checks++;
    if (g !== e) begin failures++; $display("wrong value %0t %h %h", $time, g, e); end
  endtask
  task results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task w(int n); repeat (n) @(posedge ref_clk); #2; endtask
  initial begin
    w(20);
    resetn = 1;
    w(4);
    chk(md, 0);
    foreach (t[i]) begin
      u_pms_host.send(t[i][19], t[i][18], t[i][17:10]);
      w(3);
      chk(md, t[i][9:8]);
      chk(co, t[i][7:0]);
    end
    $display("mode table done");
    vdd = 0;
    w(4);
    chk(so, 0);
    chk(sa, 0);
    // Refused: serial side is down
    u_pms_host.send(0, 1, 0);
    w(3);
    chk(co, 8'h3C);
    vdd = 1;
    vbb = 0;
    w(4);
    chk(cb, 0);
    chk(sa, 1);
    sr = 1;
    w(8);
    sr = 0;
    // Serial out is registered one edge behind the shift register
    w(1);
    chk(so, 1);
    vbb = 1;
    lh = 1;
    w(5);
    chk(co, 8'hA5);
    lh = 0;
    w(5);
    chk(md, 0);
    $display("supply and limp done");
    results;
  end
endmodule // pms_power_mode_sequencer_tb
`default_nettype wire
